// ---- rtl/mbg_guard.sv ----
// mode based memory access guard between processor core and memories
// assumes the core waits for a response before the next access and
// that memory answers a forwarded access with mem_ack some cycles later
`timescale 1ns/10ps
`default_nettype none
module mbg_guard import mbg_pkg::*; #(
   parameter int AREAS = MBG_AREAS
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // core access port
   input wire logic irq_active,
   input wire mbg_acc_t acc,
   output logic acc_ready,
   output mbg_rsp_t rsp,
   output logic violation,
   // core configuration port
   input wire mbg_cfg_t cfg,
   output logic cfg_done,
   output logic cfg_refused,
   output logic cfg_locked,
   // memory side
   output mbg_acc_t mem,
   input wire logic mem_ack,
   input wire logic [MBG_DW-1:0] mem_rdata
);

   typedef struct packed {
      mbg_fsm_t fsm;
      logic acc_ready;
      mbg_rsp_t rsp;
      logic violation;
      logic cfg_done;
      logic cfg_refused;
      logic locked;
      mbg_acc_t mem;
      mbg_area_t [AREAS-1:0] areas;
   } mbg_regs_t;

   mbg_regs_t st_ff;
   mbg_regs_t nxt_st;
   logic grant;

   // one area's verdict for a given mode and operation
   function automatic logic area_allows(mbg_area_t a, logic sys, mbg_op_t op);
      logic [3:0] perm;
      perm = sys ? a.perm_sys : a.perm_app;
      return perm[op];
   endfunction

   function automatic logic area_hit(mbg_area_t a, logic [MBG_AW-1:0] addr);
      return a.valid && (addr >= a.base) && (addr <= a.limit);
   endfunction

   // lowest numbered hitting area decides; an address no area covers is refused,
   // so software keeps the catch-all background in the highest numbered area
   always_comb begin
      grant = 1'b0;
      for (int i = AREAS - 1; i >= 0; i--) begin
         if (area_hit(st_ff.areas[i], acc.addr)) begin
            grant = area_allows(st_ff.areas[i], irq_active, acc.op);
         end
      end
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_st.violation = 1'b0;
      nxt_st.cfg_done = 1'b0;
      nxt_st.cfg_refused = 1'b0;
      nxt_st.rsp.valid = 1'b0;
      case (st_ff.fsm)
         MBG_ST_IDLE: begin
            if (acc.req && st_ff.acc_ready) begin
               if (grant) begin
                  // only a granted access ever reaches the memory
                  nxt_st.mem = acc;
                  nxt_st.mem.req = 1'b1;
                  nxt_st.acc_ready = 1'b0;
                  nxt_st.fsm = MBG_ST_WAIT;
               end else begin
                  nxt_st.rsp.valid = 1'b1;
                  nxt_st.rsp.denied = 1'b1;
                  nxt_st.rsp.rdata = '0;
                  nxt_st.violation = 1'b1;
               end
            end
         end
         MBG_ST_WAIT: begin
            if (mem_ack) begin
               nxt_st.mem = '0;
               nxt_st.rsp.valid = 1'b1;
               nxt_st.rsp.denied = 1'b0;
               nxt_st.rsp.rdata = (st_ff.mem.op == MBG_OP_READ || st_ff.mem.op == MBG_OP_EXEC) ? mem_rdata : '0;
               nxt_st.acc_ready = 1'b1;
               nxt_st.fsm = MBG_ST_IDLE;
            end
         end
         default: begin
            nxt_st.mem = '0;
            nxt_st.acc_ready = 1'b1;
            nxt_st.fsm = MBG_ST_IDLE;
         end
      endcase
      // attribute management; a lock makes the set final until reset
      if (cfg.wr) begin
         if (!irq_active || st_ff.locked || cfg.idx >= MBG_IDXW'(AREAS)) begin
            nxt_st.cfg_refused = 1'b1;
         end else begin
            nxt_st.cfg_done = 1'b1;
            case (cfg.cmd)
               MBG_CMD_SET: nxt_st.areas[cfg.idx] = cfg.area;
               MBG_CMD_DEL: nxt_st.areas[cfg.idx] = MBG_RST_AREA_OFF;
               MBG_CMD_LOCK: nxt_st.locked = 1'b1;
               default: nxt_st.cfg_done = 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_ff <= '0;
         st_ff.fsm <= MBG_ST_IDLE;
         st_ff.acc_ready <= 1'b1;
         for (int i = 0; i < AREAS; i++) begin
            st_ff.areas[i] <= (i == 0) ? MBG_RST_AREA0 : MBG_RST_AREA_OFF;
         end
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign acc_ready = st_ff.acc_ready;
   assign rsp = st_ff.rsp;
   assign violation = st_ff.violation;
   assign cfg_done = st_ff.cfg_done;
   assign cfg_refused = st_ff.cfg_refused;
   assign cfg_locked = st_ff.locked;
   assign mem = st_ff.mem;

endmodule // mbg_guard
`default_nettype wire

// ---- rtl/mbg_pkg.sv ----
// constants and types for the mode based memory access guard
// assumes one clock domain and a core that holds at most one access open
package mbg_pkg;

   localparam int MBG_AW = 16;
   localparam int MBG_DW = 8;
   localparam int MBG_AREAS = 4;
   localparam int MBG_IDXW = 8;

   // permission nibble: one bit per operation, indexed by the op code
   typedef enum logic [1:0] {
      MBG_OP_READ = 2'h0,
      MBG_OP_WRITE = 2'h1,
      MBG_OP_DELETE = 2'h2,
      MBG_OP_EXEC = 2'h3
   } mbg_op_t;

   typedef enum logic [1:0] {
      MBG_CMD_SET = 2'h0,
      MBG_CMD_DEL = 2'h1,
      MBG_CMD_LOCK = 2'h2,
      MBG_CMD_NOP = 2'h3
   } mbg_cmd_t;

   typedef enum logic [1:0] {
      MBG_ST_IDLE = 2'h0,
      MBG_ST_WAIT = 2'h1
   } mbg_fsm_t;

   typedef struct packed {
      logic valid;
      logic [MBG_AW-1:0] base;
      logic [MBG_AW-1:0] limit;
      logic [3:0] perm_sys;
      logic [3:0] perm_app;
   } mbg_area_t;

   typedef struct packed {
      logic req;
      mbg_op_t op;
      logic [MBG_AW-1:0] addr;
      logic [MBG_DW-1:0] wdata;
   } mbg_acc_t;

   typedef struct packed {
      logic valid;
      logic denied;
      logic [MBG_DW-1:0] rdata;
   } mbg_rsp_t;

   typedef struct packed {
      logic wr;
      mbg_cmd_t cmd;
      logic [MBG_IDXW-1:0] idx;
      mbg_area_t area;
   } mbg_cfg_t;

   // manufacture defaults: area 0 spans all memory, system full rights, application read and execute
   localparam mbg_area_t MBG_RST_AREA0 = '{valid: 1'b1, base: 16'h0000, limit: 16'hFFFF,
                                          perm_sys: 4'hF, perm_app: 4'h9};
   localparam mbg_area_t MBG_RST_AREA_OFF = '{valid: 1'b0, base: 16'h0000, limit: 16'h0000,
                                             perm_sys: 4'h0, perm_app: 4'h0};

endpackage

// ---- test/mbg_checker.sv ----
// port assertions for the guard
// bound in from the bench top file
`timescale 1ns/10ps
`default_nettype none
module mbg_checker import mbg_pkg::*; #(parameter int AREAS = MBG_AREAS) (
   // guard ports
   input wire logic sys_clk, rst, irq_active, acc_ready, violation, cfg_refused, cfg_locked, mem_ack,
   input wire mbg_acc_t acc, mem,
   input wire mbg_rsp_t rsp,
   input wire mbg_cfg_t cfg
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_rst; $fell(rst) |-> acc_ready && !cfg_locked; endproperty
   a_rst: assert property (p_rst) else $error("reset");
   property p_take; acc.req && acc_ready |=> mem.req != rsp.valid; endproperty
   a_take: assert property (p_take) else $error("take");
   property p_fwd;
      acc.req && acc_ready |=> !mem.req || (mem.addr == $past(acc.addr) && mem.op == $past(acc.op)
                                           && mem.wdata == $past(acc.wdata));
   endproperty
   a_fwd: assert property (p_fwd) else $error("forward");
   property p_hold; mem.req && !mem_ack |=> $stable(mem); endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_ack; mem.req && mem_ack |=> rsp.valid && !violation; endproperty
   a_ack: assert property (p_ack) else $error("answer");
   property p_deny; violation |-> rsp.denied && !mem.req; endproperty
   a_deny: assert property (p_deny) else $error("deny");
   property p_mode; cfg.wr && !irq_active |=> cfg_refused; endproperty
   a_mode: assert property (p_mode) else $error("mode");
   property p_lock; cfg.wr && cfg_locked |=> cfg_refused; endproperty
   a_lock: assert property (p_lock) else $error("lock");
   property p_idx; cfg.wr && cfg.idx >= AREAS |=> cfg_refused; endproperty
   a_idx: assert property (p_idx) else $error("index");
   c_deny: cover property (violation);
   c_mem: cover property (mem_ack);
   c_lock: cover property (cfg_locked);
endmodule // mbg_checker
`default_nettype wire

// ---- test/mbg_mem_model.sv ----
// memory stand-in for the guard
// answers after lat waits; data toggles between answers
`timescale 1ns/10ps
`default_nettype none
module mbg_mem_model import mbg_pkg::*; (
   // guard side
   input wire logic sys_clk,
   input wire mbg_acc_t mem,
   input wire logic [3:0] lat,
   output logic mem_ack,
   output logic [MBG_DW-1:0] mem_rdata
);
   logic [3:0] cnt;
   logic hit;
   assign hit = mem.req && !mem_ack && cnt >= lat;
   always @(posedge sys_clk) begin
      mem_ack <= hit;
      mem_rdata <= hit ? mem.addr[7:0] ^ 8'h5A : ~mem_rdata;
      cnt <= mem.req ? cnt + 4'h1 : 4'h0;
   end
endmodule // mbg_mem_model
`default_nettype wire

// ---- test/mbg_guard_test.sv ----
// bench for the guard
// core side driven at rising edges
`timescale 1ns/10ps
`default_nettype none
module mbg_guard_test import mbg_pkg::*;;
   logic sys_clk = 1'b0, rst = 1'b1, irq_active = 1'b0, acc_ready, violation, cfg_done, cfg_refused;
   logic cfg_locked, mem_ack;
   logic [3:0] lat = 4'h0;
   logic [7:0] mem_rdata;
   mbg_acc_t acc = '0, mem;
   mbg_rsp_t rsp;
   mbg_cfg_t cfg = '0;
   int fails = 0, checked = 0;
   mbg_guard uut (.*);
   mbg_mem_model mm (.*);
   initial forever #4 sys_clk = ~sys_clk;
   initial #9000 begin
      fails++;
      test_done;
   end
   task automatic test_done;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // request stands only for the edge that takes it
   task automatic ac(input logic m, input mbg_op_t o, input logic [15:0] a, input logic den);
      @(posedge sys_clk);
      irq_active <= m;
      acc <= '{1'b1, o, a, 8'h3C};
      @(posedge sys_clk);
      acc.req <= 1'b0;
      #1;
      for (int n = 0; n < 40 && !rsp.valid; n++) @(posedge sys_clk) #1;
      chk({rsp.valid, rsp.denied, violation}, {1'b1, den, den});
      chk(rsp.rdata, (!den && o inside {MBG_OP_READ, MBG_OP_EXEC}) ? a[7:0] ^ 8'h5A : 8'h00);
   endtask
   task automatic cf(input logic m, input mbg_cmd_t c, input logic [7:0] i, input logic ok);
      @(posedge sys_clk);
      irq_active <= m;
      cfg <= '{1'b1, c, i, '{1'b1, 16'h0010, 16'h001F, 4'hF, 4'hF}};
      @(posedge sys_clk);
      cfg.wr <= 1'b0;
      #1;
      chk({cfg_done, cfg_refused}, {ok, !ok});
   endtask
   task automatic t_dflt;
      #1;
      chk({acc_ready, cfg_locked}, 2'b10);
      ac(1, MBG_OP_WRITE, 16'h0010, 0);
      ac(0, MBG_OP_WRITE, 16'h0010, 1);
      ac(0, MBG_OP_READ, 16'h0011, 0);
      ac(0, MBG_OP_EXEC, 16'h0012, 0);
      ac(0, MBG_OP_DELETE, 16'h0010, 1);
      $display("defaults done");
   endtask
   task automatic t_cfg;
      lat <= 4'h3;
      cf(0, MBG_CMD_SET, 8'h00, 0);
      ac(0, MBG_OP_WRITE, 16'h001F, 1);
      cf(1, MBG_CMD_SET, 8'h04, 0);
      cf(1, MBG_CMD_SET, 8'h00, 1);
      ac(0, MBG_OP_WRITE, 16'h001F, 0);
      ac(1, MBG_OP_READ, 16'h0020, 1);
      cf(1, MBG_CMD_LOCK, 8'h01, 1);
      chk(cfg_locked, 1'b1);
      cf(1, MBG_CMD_DEL, 8'h00, 0);
      ac(0, MBG_OP_READ, 16'h0013, 0);
      $display("config done");
   endtask
   initial begin
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      t_dflt;
      t_cfg;
      test_done;
   end
endmodule // mbg_guard_test
bind mbg_guard mbg_checker #(.AREAS(AREAS)) chk_i (.*);
`default_nettype wire
